/* File: e1_align_pkg.sv */
// Register map, field layout, reset values and counts for the E1 receive alignment control
package e1_align_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_FRAME_ALIGNMENT_OPTIONS  = 8'h30;
	localparam logic [7:0] IDX_MAINTENANCE_MODE_OPTIONS = 8'h31;
	localparam logic [7:0] IDX_FRAMING_IRQ_ENABLE       = 8'h32;
	localparam logic [7:0] IDX_ALARM_IRQ_ENABLE         = 8'h33;
	localparam logic [7:0] IDX_FRAMING_IRQ_INDICATION   = 8'h34;
	localparam logic [7:0] IDX_ALARM_IRQ_INDICATION     = 8'h35;
	localparam logic [7:0] IDX_FRAMING_STATUS           = 8'h36;
	localparam logic [7:0] IDX_ALARM_STATUS             = 8'h37;

	// frame_alignment_options fields
	localparam int FA_CRC_SEARCH = 7;
	localparam int FA_SMF_DISABLE = 6;
	localparam int FA_IW_CONTINUE = 5;
	localparam int FA_FORCE_SEARCH = 2;
	localparam int FA_EXCESS_EN = 1;
	localparam int FA_FRAME_LOCK = 0;
	localparam logic [7:0] FA_WRITE_MASK = 8'hE7;
	localparam logic [7:0] FA_RESET = 8'h82;

	// maintenance_mode_options fields
	localparam int MM_EXTRA_OOF = 6;
	localparam int MM_ZERO_CONTENT = 5;
	localparam int MM_ZERO_SPAN = 4;
	localparam int MM_RAI_PERSIST = 3;
	localparam int MM_AIS_CRITERION = 1;
	localparam int MM_EXCESS_FLAG = 0;
	localparam logic [7:0] MM_WRITE_MASK = 8'h7A;
	localparam logic [7:0] MM_RESET = 8'h40;

	// Enable registers
	localparam logic [7:0] FRAMING_ENABLE_RESET = 8'h02;
	localparam logic [7:0] ALARM_ENABLE_RESET = 8'h00;
	localparam logic [7:0] ALARM_ENABLE_MASK = 8'hEF;

	// Framing indication / status bit positions
	localparam int IND_INTERWORK = 7;
	localparam int IND_OOF = 6;
	localparam int IND_OOSMF = 5;
	localparam int IND_OOCMF = 4;
	localparam int IND_SHIFT = 3;
	localparam int IND_FAS_ERR = 2;
	localparam int IND_SMF_ERR = 1;
	localparam int IND_CMF_ERR = 0;
	// Alarm indication / status bit positions
	localparam int IND_RAI = 7;
	localparam int IND_RMAI = 6;
	localparam int IND_AIS = 5;

	// Alignment and alarm criteria
	localparam logic [1:0] FAS_LOSS_COUNT = 2'h3;
	localparam logic [1:0] BIT2_LOSS_COUNT = 2'h3;
	localparam logic [1:0] SMF_LOSS_COUNT = 2'h2;
	localparam logic [2:0] RAI_PERSIST_COUNT = 3'h4;
	localparam logic [1:0] AIS_ZERO_LIMIT = 2'h3;
	localparam logic [8:0] AIS_WINDOW_LAST = 9'h1FF;
	localparam logic [9:0] CRC_EXCESS_LIMIT = 10'h392;

	// One-second CRC window
	localparam longint CLK_HZ = 125000000;
	localparam longint CRC_WINDOW_S = 1;
	localparam longint SEC_CYCLES = CRC_WINDOW_S * CLK_HZ;

	typedef enum logic [0:0] {
		SYNC_SEARCH   = 1'b0,
		SYNC_IN_FRAME = 1'b1
	} frame_state_t;
endpackage

/* File: e1_frame_alignment_alarm_control.sv */
// Receive frame alignment, alarm criteria and interrupt gating for one E1 channel
//
// Register access over AHB-Lite was decided locally.
module e1_frame_alignment_alarm_control #(
	parameter longint SEC_CYCLES = e1_align_pkg::SEC_CYCLES
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Line events from the receive datapath
	input  wire logic        bit_valid,
	input  wire logic        bit_data,
	input  wire logic        frame_found,
	input  wire logic        alignment_shift,
	input  wire logic        fas_check,
	input  wire logic        fas_error,
	input  wire logic        nfas_check,
	input  wire logic        nfas_bit2,
	input  wire logic        a_bit_valid,
	input  wire logic        a_bit,
	input  wire logic        smf_check,
	input  wire logic        smf_error,
	input  wire logic        smf_found,
	input  wire logic        ts16_check,
	input  wire logic        ts16_all_zero,
	input  wire logic        crc_mf_found,
	input  wire logic        crc_mf_error,
	input  wire logic        crc_check,
	input  wire logic        crc_mismatch,
	input  wire logic        interworking,
	input  wire logic        remote_mf_alarm,
	// Control and status out
	output logic             frame_search_restart,
	output logic             out_of_frame,
	output logic             crc_mf_search,
	output logic             smf_search,
	output logic             remote_alarm_state,
	output logic             ais_detected_state,
	output logic             irq_n
);
	typedef struct packed {
		logic [7:0]                 fa;
		logic [7:0]                 mm;
		logic [7:0]                 ena0;
		logic [7:0]                 ena1;
		logic [7:0]                 ind0;
		logic [7:0]                 ind1;
		logic                       exc_flag;
		e1_align_pkg::frame_state_t state;
		logic                       locked;
		logic                       oosmf;
		logic                       oocmf;
		logic                       rai;
		logic                       ais;
		logic                       iw_q;
		logic                       rmai_q;
		logic [1:0]                 fas_cnt;
		logic [1:0]                 b2_cnt;
		logic [1:0]                 smf_cnt;
		logic                       zc_cnt;
		logic [2:0]                 a_cnt;
		logic [1:0]                 zeros;
		logic [8:0]                 bit_cnt;
		logic                       prev_low;
		logic [9:0]                 crc_cnt;
		logic [31:0]                sec_cnt;
		logic                       dp_wr;
		logic [7:0]                 dp_idx;
		logic [7:0]                 rdata;
		logic                       restart;
		logic                       irq_n;
	} state_t;

	state_t st;
	state_t next_st;

	logic       addr_ok;
	logic [7:0] addr_idx;
	logic       rd;
	logic       force_new_frame_search_rise;
	logic       sec_tick;
	logic       excess_evt;
	logic       loss_fas;
	logic       loss_b2;
	logic       smf_en;
	logic       crc_allowed;
	logic       win_low;
	logic [7:0] set0;
	logic [7:0] set1;

	always_comb begin
		next_st = st;
		addr_ok = hsel && htrans[1] && hready;
		addr_idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'h00;
		rd = addr_ok && !hwrite;
		next_st.dp_wr = addr_ok && hwrite;
		next_st.dp_idx = addr_idx;
		next_st.restart = 1'b0;

		// Data phase of a write; unmapped indices are dropped
		force_new_frame_search_rise = 1'b0;
		if (st.dp_wr) begin
			if (st.dp_idx == e1_align_pkg::IDX_FRAME_ALIGNMENT_OPTIONS) begin
				next_st.fa = hwdata[7:0] & e1_align_pkg::FA_WRITE_MASK;
				force_new_frame_search_rise = hwdata[e1_align_pkg::FA_FORCE_SEARCH]
					&& !st.fa[e1_align_pkg::FA_FORCE_SEARCH];
			end else if (st.dp_idx == e1_align_pkg::IDX_MAINTENANCE_MODE_OPTIONS) begin
				next_st.mm = hwdata[7:0] & e1_align_pkg::MM_WRITE_MASK;
			end else if (st.dp_idx == e1_align_pkg::IDX_FRAMING_IRQ_ENABLE) begin
				next_st.ena0 = hwdata[7:0];
			end else if (st.dp_idx == e1_align_pkg::IDX_ALARM_IRQ_ENABLE) begin
				next_st.ena1 = hwdata[7:0] & e1_align_pkg::ALARM_ENABLE_MASK;
			end
		end

		// One-second window for CRC error counting
		sec_tick = (st.sec_cnt == 32'(SEC_CYCLES - 1));
		next_st.sec_cnt = sec_tick ? 32'h0 : st.sec_cnt + 32'h1;
		excess_evt = 1'b0;
		if (sec_tick) begin
			next_st.crc_cnt = 10'h000;
		end else if (crc_check && crc_mismatch && st.fa[e1_align_pkg::FA_CRC_SEARCH]
				&& st.state == e1_align_pkg::SYNC_IN_FRAME) begin
			if (st.crc_cnt == e1_align_pkg::CRC_EXCESS_LIMIT) begin
				excess_evt = 1'b1;
			end
			if (st.crc_cnt <= e1_align_pkg::CRC_EXCESS_LIMIT) begin
				next_st.crc_cnt = st.crc_cnt + 10'h001;
			end
		end

		// Consecutive FAS errors and bit-2 zeros
		loss_fas = fas_check && fas_error
			&& st.fas_cnt == e1_align_pkg::FAS_LOSS_COUNT - 2'h1;
		loss_b2 = nfas_check && !nfas_bit2 && st.mm[e1_align_pkg::MM_EXTRA_OOF]
			&& st.b2_cnt == e1_align_pkg::BIT2_LOSS_COUNT - 2'h1;
		if (fas_check) begin
			next_st.fas_cnt = fas_error ? st.fas_cnt + 2'h1 : 2'h0;
		end
		if (nfas_check) begin
			next_st.b2_cnt = !nfas_bit2 ? st.b2_cnt + 2'h1 : 2'h0;
		end

		// Basic frame alignment
		case (st.state)
			e1_align_pkg::SYNC_SEARCH: begin
				if (force_new_frame_search_rise) begin
					next_st.restart = 1'b1;
				end else if (frame_found) begin
					next_st.state = e1_align_pkg::SYNC_IN_FRAME;
					next_st.locked = 1'b1;
				end
			end
			e1_align_pkg::SYNC_IN_FRAME: begin
				if (force_new_frame_search_rise) begin
					next_st.state = e1_align_pkg::SYNC_SEARCH;
					next_st.restart = 1'b1;
				end else if (!(st.fa[e1_align_pkg::FA_FRAME_LOCK] && st.locked)
						&& (loss_fas || loss_b2
						|| (excess_evt && st.fa[e1_align_pkg::FA_EXCESS_EN]))) begin
					next_st.state = e1_align_pkg::SYNC_SEARCH;
					next_st.restart = 1'b1;
				end
			end
			default: next_st.state = e1_align_pkg::SYNC_SEARCH;
		endcase
		if (next_st.state == e1_align_pkg::SYNC_SEARCH) begin
			next_st.fas_cnt = 2'h0;
			next_st.b2_cnt = 2'h0;
		end

		// Signaling multiframe
		smf_en = !st.fa[e1_align_pkg::FA_SMF_DISABLE]
			&& st.state == e1_align_pkg::SYNC_IN_FRAME;
		if (!smf_en) begin
			next_st.oosmf = 1'b1;
			next_st.smf_cnt = 2'h0;
			next_st.zc_cnt = 1'b0;
		end else if (st.oosmf) begin
			next_st.oosmf = !smf_found;
		end else begin
			if (smf_check) begin
				next_st.smf_cnt = smf_error ? st.smf_cnt + 2'h1 : 2'h0;
				if (smf_error && st.smf_cnt == e1_align_pkg::SMF_LOSS_COUNT - 2'h1) begin
					next_st.oosmf = 1'b1;
				end
			end
			if (ts16_check) begin
				next_st.zc_cnt = ts16_all_zero && !st.zc_cnt;
				if (ts16_all_zero && st.mm[e1_align_pkg::MM_ZERO_CONTENT]
						&& (!st.mm[e1_align_pkg::MM_ZERO_SPAN] || st.zc_cnt)) begin
					next_st.oosmf = 1'b1;
				end
			end
			if (next_st.oosmf) begin
				next_st.smf_cnt = 2'h0;
				next_st.zc_cnt = 1'b0;
			end
		end

		// CRC multiframe
		crc_allowed = st.fa[e1_align_pkg::FA_CRC_SEARCH]
			&& st.state == e1_align_pkg::SYNC_IN_FRAME
			&& (!interworking || st.fa[e1_align_pkg::FA_IW_CONTINUE]);
		if (!st.fa[e1_align_pkg::FA_CRC_SEARCH] || st.state == e1_align_pkg::SYNC_SEARCH) begin
			next_st.oocmf = 1'b1;
		end else if (st.oocmf && crc_mf_found && crc_allowed) begin
			next_st.oocmf = 1'b0;
		end

		// Remote alarm from A bits
		if (a_bit_valid) begin
			if (!a_bit) begin
				next_st.a_cnt = 3'h0;
				next_st.rai = 1'b0;
			end else begin
				if (st.a_cnt != e1_align_pkg::RAI_PERSIST_COUNT) begin
					next_st.a_cnt = st.a_cnt + 3'h1;
				end
				next_st.rai = !st.mm[e1_align_pkg::MM_RAI_PERSIST]
					|| st.a_cnt >= e1_align_pkg::RAI_PERSIST_COUNT - 3'h1;
			end
		end

		// AIS: zeros counted per 512-bit window
		win_low = 1'b0;
		if (bit_valid) begin
			next_st.bit_cnt = st.bit_cnt + 9'h001;
			if (!bit_data && st.zeros != e1_align_pkg::AIS_ZERO_LIMIT) begin
				next_st.zeros = st.zeros + 2'h1;
			end
			if (st.bit_cnt == e1_align_pkg::AIS_WINDOW_LAST) begin
				win_low = (next_st.zeros != e1_align_pkg::AIS_ZERO_LIMIT);
				next_st.zeros = 2'h0;
				next_st.prev_low = win_low;
				if (!st.mm[e1_align_pkg::MM_AIS_CRITERION]) begin
					if (win_low && st.state == e1_align_pkg::SYNC_SEARCH) begin
						next_st.ais = 1'b1;
					end else if (!win_low) begin
						next_st.ais = 1'b0;
					end
				end else begin
					if (win_low && st.prev_low && st.state == e1_align_pkg::SYNC_SEARCH) begin
						next_st.ais = 1'b1;
					end else if (!win_low && !st.prev_low) begin
						next_st.ais = 1'b0;
					end
				end
			end
		end

		// Change and error indications; a set in the read cycle survives the clear
		next_st.iw_q = interworking;
		next_st.rmai_q = remote_mf_alarm;
		set0 = 8'h00;
		set0[e1_align_pkg::IND_INTERWORK] = interworking != st.iw_q;
		set0[e1_align_pkg::IND_OOF] = next_st.state != st.state;
		set0[e1_align_pkg::IND_OOSMF] = next_st.oosmf != st.oosmf;
		set0[e1_align_pkg::IND_OOCMF] = next_st.oocmf != st.oocmf;
		set0[e1_align_pkg::IND_SHIFT] = alignment_shift;
		set0[e1_align_pkg::IND_FAS_ERR] = fas_check && fas_error;
		set0[e1_align_pkg::IND_SMF_ERR] = smf_check && smf_error && smf_en && !st.oosmf;
		set0[e1_align_pkg::IND_CMF_ERR] = crc_mf_error && st.fa[e1_align_pkg::FA_CRC_SEARCH];
		set1 = 8'h00;
		set1[e1_align_pkg::IND_RAI] = next_st.rai != st.rai;
		set1[e1_align_pkg::IND_RMAI] = remote_mf_alarm != st.rmai_q;
		set1[e1_align_pkg::IND_AIS] = next_st.ais != st.ais;
		if (rd && addr_idx == e1_align_pkg::IDX_FRAMING_IRQ_INDICATION) begin
			next_st.ind0 = set0;
		end else begin
			next_st.ind0 = st.ind0 | set0;
		end
		if (rd && addr_idx == e1_align_pkg::IDX_ALARM_IRQ_INDICATION) begin
			next_st.ind1 = set1;
		end else begin
			next_st.ind1 = st.ind1 | set1;
		end
		if (rd && addr_idx == e1_align_pkg::IDX_MAINTENANCE_MODE_OPTIONS) begin
			next_st.exc_flag = excess_evt;
		end else begin
			next_st.exc_flag = st.exc_flag || excess_evt;
		end

		// Read data sees a write still in its data phase
		next_st.rdata = 8'h00;
		if (rd) begin
			if (addr_idx == e1_align_pkg::IDX_FRAME_ALIGNMENT_OPTIONS) begin
				next_st.rdata = next_st.fa;
			end else if (addr_idx == e1_align_pkg::IDX_MAINTENANCE_MODE_OPTIONS) begin
				next_st.rdata = {next_st.mm[7:1], st.exc_flag};
			end else if (addr_idx == e1_align_pkg::IDX_FRAMING_IRQ_ENABLE) begin
				next_st.rdata = next_st.ena0;
			end else if (addr_idx == e1_align_pkg::IDX_ALARM_IRQ_ENABLE) begin
				next_st.rdata = next_st.ena1;
			end else if (addr_idx == e1_align_pkg::IDX_FRAMING_IRQ_INDICATION) begin
				next_st.rdata = st.ind0;
			end else if (addr_idx == e1_align_pkg::IDX_ALARM_IRQ_INDICATION) begin
				next_st.rdata = st.ind1;
			end else if (addr_idx == e1_align_pkg::IDX_FRAMING_STATUS) begin
				next_st.rdata = {st.iw_q, st.state == e1_align_pkg::SYNC_SEARCH,
					st.oosmf, st.oocmf, 4'h0};
			end else if (addr_idx == e1_align_pkg::IDX_ALARM_STATUS) begin
				next_st.rdata = {st.rai, st.rmai_q, st.ais, 5'h00};
			end
		end

		next_st.irq_n = !(|((next_st.ind0 & next_st.ena0)
			| (next_st.ind1 & next_st.ena1)));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.fa <= e1_align_pkg::FA_RESET;
			st.mm <= e1_align_pkg::MM_RESET;
			st.ena0 <= e1_align_pkg::FRAMING_ENABLE_RESET;
			st.ena1 <= e1_align_pkg::ALARM_ENABLE_RESET;
			st.state <= e1_align_pkg::SYNC_SEARCH;
			st.oosmf <= 1'b1;
			st.oocmf <= 1'b1;
			st.irq_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Zero-wait slave: every transfer completes OKAY in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = {24'h000000, st.rdata};
	assign frame_search_restart = st.restart;
	assign out_of_frame = st.state == e1_align_pkg::SYNC_SEARCH;
	assign crc_mf_search = st.oocmf && st.fa[e1_align_pkg::FA_CRC_SEARCH]
		&& st.state == e1_align_pkg::SYNC_IN_FRAME
		&& (!st.iw_q || st.fa[e1_align_pkg::FA_IW_CONTINUE]);
	assign smf_search = st.oosmf && !st.fa[e1_align_pkg::FA_SMF_DISABLE]
		&& st.state == e1_align_pkg::SYNC_IN_FRAME;
	assign remote_alarm_state = st.rai;
	assign ais_detected_state = st.ais;
	assign irq_n = st.irq_n;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_force_restart: assert property (force_new_frame_search_rise |=> out_of_frame && frame_search_restart)
		else $error("force search did not restart frame search");
	a_fas_loss: assert property (loss_fas && !out_of_frame && !st.fa[e1_align_pkg::FA_FRAME_LOCK]
		|=> out_of_frame)
		else $error("three FAS errors did not drop frame");
	a_bit2_loss: assert property (loss_b2 && !out_of_frame && !st.fa[e1_align_pkg::FA_FRAME_LOCK]
		|=> out_of_frame)
		else $error("bit 2 criterion did not drop frame");
	a_lock_holds: assert property (!out_of_frame && st.locked
		&& st.fa[e1_align_pkg::FA_FRAME_LOCK] && !force_new_frame_search_rise |=> !out_of_frame)
		else $error("locked frame was dropped");
	a_excess_flag: assert property (excess_evt |=> st.exc_flag)
		else $error("excess CRC flag not set");
	a_rai_clear: assert property (a_bit_valid && !a_bit |=> !remote_alarm_state)
		else $error("A bit zero did not clear remote alarm");
	a_rai_persist: assert property ($past(st.mm[e1_align_pkg::MM_RAI_PERSIST])
		&& $rose(remote_alarm_state)
		|-> $past(a_bit_valid) && $past(st.a_cnt) >= 3'h3)
		else $error("remote alarm set before four ones");
	a_ais_needs_oof: assert property ($rose(ais_detected_state) |-> $past(out_of_frame))
		else $error("AIS set while in frame");
	a_smf_loss: assert property (smf_check && smf_error && smf_en && !st.oosmf
		&& st.smf_cnt == 2'h1 |=> st.oosmf)
		else $error("two bad signaling patterns did not drop sync");
	a_ind_read_clear: assert property (rd && addr_idx == e1_align_pkg::IDX_FRAMING_IRQ_INDICATION
		&& set0 == 8'h00 |=> st.ind0 == 8'h00)
		else $error("framing indications not cleared by read");
	a_irq_gate: assert property (irq_n == !(|((st.ind0 & st.ena0) | (st.ind1 & st.ena1))))
		else $error("interrupt does not match enabled indications");

	c_frame_found: cover property (out_of_frame ##1 !out_of_frame);
	c_excess: cover property (excess_evt);
	c_ais_set: cover property ($rose(ais_detected_state));
	c_irq: cover property ($fell(irq_n));
endmodule // e1_frame_alignment_alarm_control

/* File: e1_line_model.sv */
// Behavioural far-end E1 line model producing receive-side events
module e1_line_model (
	// Clock
	input  wire logic hclk,
	// Line events toward the alignment control
	output logic      bit_valid,
	output logic      bit_data,
	output logic      frame_found,
	output logic      alignment_shift,
	output logic      fas_check,
	output logic      fas_error,
	output logic      nfas_check,
	output logic      nfas_bit2,
	output logic      a_bit_valid,
	output logic      a_bit,
	output logic      smf_check,
	output logic      smf_error,
	output logic      smf_found,
	output logic      ts16_check,
	output logic      ts16_all_zero,
	output logic      crc_mf_found,
	output logic      crc_mf_error,
	output logic      crc_check,
	output logic      crc_mismatch,
	output logic      interworking,
	output logic      remote_mf_alarm
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{bit_valid, bit_data, frame_found, alignment_shift, fas_check, fas_error, nfas_check,
			nfas_bit2, a_bit_valid, a_bit, smf_check, smf_error, smf_found, ts16_check,
			ts16_all_zero, crc_mf_found, crc_mf_error, crc_check, crc_mismatch, interworking,
			remote_mf_alarm} = '0;
	end

	// Strobes held n cycles back to back; data then flips so a stale value never passes
	task automatic send(input int kind, input logic v, input int n);
		repeat (n) begin
			@(posedge hclk);
			case (kind)
				0: {fas_check, fas_error} <= {1'b1, v};
				1: {a_bit_valid, a_bit} <= {1'b1, v};
				2: {crc_check, crc_mismatch} <= {1'b1, v};
				3: {bit_valid, bit_data} <= {1'b1, v};
				4: frame_found <= 1'b1;
				5: interworking <= v;
				6: {nfas_check, nfas_bit2} <= {1'b1, v};
				7: smf_found <= 1'b1;
				8: {smf_check, smf_error} <= {1'b1, v};
				9: alignment_shift <= 1'b1;
				11: {ts16_check, ts16_all_zero} <= {1'b1, v};
				12: crc_mf_found <= 1'b1;
				13: crc_mf_error <= 1'b1;
				default: remote_mf_alarm <= v;
			endcase
		end
		@(posedge hclk);
		{fas_check, a_bit_valid, crc_check, bit_valid, frame_found} <= '0;
		{nfas_check, smf_found, smf_check, alignment_shift} <= '0;
		{ts16_check, crc_mf_found, crc_mf_error} <= '0;
		{fas_error, a_bit, crc_mismatch, bit_data, nfas_bit2, smf_error, ts16_all_zero} <= {7{~v}};
	endtask
endmodule // e1_line_model

/* File: tb.sv */
// Self-checking bench for the E1 receive alignment and alarm control
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] FA = e1_align_pkg::IDX_FRAME_ALIGNMENT_OPTIONS;
	localparam logic [7:0] MM = e1_align_pkg::IDX_MAINTENANCE_MODE_OPTIONS;
	localparam logic [7:0] EN0 = e1_align_pkg::IDX_FRAMING_IRQ_ENABLE;
	localparam logic [7:0] EN1 = e1_align_pkg::IDX_ALARM_IRQ_ENABLE;
	localparam logic [7:0] IN0 = e1_align_pkg::IDX_FRAMING_IRQ_INDICATION;
	localparam logic [7:0] ST0 = e1_align_pkg::IDX_FRAMING_STATUS;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        bit_valid, bit_data, frame_found, alignment_shift, fas_check, fas_error;
	logic        nfas_check, nfas_bit2, a_bit_valid, a_bit, smf_check, smf_error, smf_found;
	logic        ts16_check, ts16_all_zero, crc_mf_found, crc_mf_error, crc_check, crc_mismatch;
	logic        interworking, remote_mf_alarm, frame_search_restart, out_of_frame;
	logic        crc_mf_search, smf_search, remote_alarm_state, ais_detected_state, irq_n;
	int          failures = 0;
	int          checked = 0;
	int          restarts = 0;

	e1_frame_alignment_alarm_control #(.SEC_CYCLES(4000)) u_dut (.hready(hreadyout), .*);
	e1_line_model u_line (.*);

	always @(posedge hclk) if (frame_search_restart === 1'b1) restarts++;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		bus(1'b1, idx, v, d);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e,
			input string what);
		logic [31:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk(what, e, d & m);
	endtask

	// Outputs follow a line event one edge later, so two edges is always settled
	task automatic ln(input int k, input logic v, input int n);
		u_line.send(k, v, n);
		repeat (2) @(posedge hclk);
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(posedge hclk);
		chk("irq_n", {31'h0, e}, {31'h0, irq_n});
	endtask

	task automatic t_reset();
		rd(FA, 32'hFFFFFFFF, 32'h82, "frame options reset");
		rd(MM, 32'hFFFFFF7C, 32'h40, "maintenance reset");
		rd(EN0, 32'hFFFFFFFF, 32'h02, "framing enable reset");
		rd(EN1, 32'hFFFFFFEF, 32'h00, "alarm enable reset");
		rd(8'h3F, 32'hFFFFFFFF, 32'h00, "unmapped read");
		chk("irq_n", 1, irq_n);
	endtask

	task automatic t_loss();
		int n;
		wr(FA, 8'h82);
		wr(EN0, 8'h40);
		ln(4, 1'b1, 1);
		chk("oof", 0, out_of_frame);
		irq_is(1'b0);
		rd(IN0, 32'h40, 32'h40, "oof change");
		rd(IN0, 32'h40, 32'h00, "oof change cleared");
		irq_is(1'b1);
		ln(0, 1'b1, 2);
		chk("oof", 0, out_of_frame);
		n = restarts;
		ln(0, 1'b1, 1);
		chk("oof", 1, out_of_frame);
		chk("restarts", n + 1, restarts);
		wr(EN0, 8'h00);
		irq_is(1'b1);
	endtask

	task automatic t_lock();
		wr(FA, 8'h83);
		ln(4, 1'b1, 1);
		ln(0, 1'b1, 3);
		chk("oof locked", 0, out_of_frame);
		ln(3, 1'b1, 1100);
		chk("ais locked", 0, ais_detected_state);
		wr(FA, 8'h87);
		repeat (2) @(posedge hclk);
		chk("oof forced", 1, out_of_frame);
		ln(3, 1'b1, 1100);
		chk("ais", 1, ais_detected_state);
		ln(3, 1'b0, 1100);
		chk("ais", 0, ais_detected_state);
	endtask

	task automatic t_rai();
		wr(MM, 8'h40);
		ln(1, 1'b1, 1);
		chk("rai", 1, remote_alarm_state);
		ln(1, 1'b0, 1);
		chk("rai", 0, remote_alarm_state);
		wr(MM, 8'h48);
		ln(1, 1'b1, 3);
		chk("rai three", 0, remote_alarm_state);
		ln(1, 1'b1, 1);
		chk("rai four", 1, remote_alarm_state);
		ln(1, 1'b0, 1);
		chk("rai", 0, remote_alarm_state);
		wr(EN1, 8'h80);
		irq_is(1'b0);
		wr(EN1, 8'h00);
	endtask

	// 2000 back-to-back mismatches put over 914 inside one 4000-cycle window
	task automatic t_excess();
		wr(FA, 8'h82);
		ln(4, 1'b1, 1);
		ln(2, 1'b1, 2000);
		chk("oof excess", 1, out_of_frame);
		rd(MM, 32'h1, 32'h1, "excess flag");
		rd(MM, 32'h1, 32'h0, "excess flag cleared");
	endtask

	task automatic t_search();
		ln(4, 1'b1, 1);
		chk("crc search", 1, crc_mf_search);
		chk("smf search", 1, smf_search);
		wr(FA, 8'h42);
		repeat (2) @(posedge hclk);
		chk("crc search", 0, crc_mf_search);
		chk("smf search", 0, smf_search);
		wr(FA, 8'h82);
		ln(5, 1'b1, 1);
		chk("crc search iw", 0, crc_mf_search);
		wr(FA, 8'hA2);
		repeat (2) @(posedge hclk);
		chk("crc search iw", 1, crc_mf_search);
		ln(5, 1'b0, 1);
		ln(6, 1'b0, 3);
		chk("oof bit2", 1, out_of_frame);
	endtask

	task automatic t_irq();
		ln(4, 1'b1, 1);
		ln(7, 1'b1, 1);
		ln(8, 1'b1, 1);
		rd(ST0, 32'h20, 32'h00, "smf one error");
		ln(8, 1'b1, 1);
		rd(ST0, 32'h20, 32'h20, "smf two errors");
		irq_is(1'b1);
		wr(EN0, 8'h02);
		irq_is(1'b0);
		wr(EN0, 8'h00);
		ln(9, 1'b1, 1);
		irq_is(1'b1);
		wr(EN0, 8'h08);
		irq_is(1'b0);
		wr(EN0, 8'h00);
		ln(10, 1'b1, 1);
		wr(EN1, 8'h40);
		irq_is(1'b0);
	endtask

	task automatic t_zero();
		wr(EN1, 8'h00);
		ln(7, 1'b1, 1);
		ln(11, 1'b1, 1);
		rd(ST0, 32'h20, 32'h00, "ts16 zero ignored");
		wr(MM, 8'h68);
		ln(11, 1'b1, 1);
		rd(ST0, 32'h20, 32'h20, "ts16 zero one");
		ln(7, 1'b1, 1);
		wr(MM, 8'h78);
		ln(11, 1'b1, 1);
		rd(ST0, 32'h20, 32'h00, "ts16 zero first of two");
		ln(11, 1'b1, 1);
		rd(ST0, 32'h20, 32'h20, "ts16 zero two");
	endtask

	task automatic t_crc_mf();
		wr(MM, 8'h42);
		ln(12, 1'b1, 1);
		rd(ST0, 32'h10, 32'h00, "crc mf found");
		irq_is(1'b1);
		wr(EN0, 8'h10);
		irq_is(1'b0);
		rd(IN0, 32'h01, 32'h00, "crc mf error idle");
		ln(13, 1'b1, 1);
		wr(EN0, 8'h01);
		irq_is(1'b0);
		wr(EN0, 8'h00);
	endtask

	// 800 bits hold at most one whole window, 1600 at least two
	task automatic t_ais_two();
		ln(6, 1'b0, 3);
		chk("oof bit2", 1, out_of_frame);
		ln(3, 1'b1, 800);
		chk("ais one window", 0, ais_detected_state);
		ln(3, 1'b1, 800);
		chk("ais two windows", 1, ais_detected_state);
		ln(3, 1'b0, 1100);
		chk("ais cleared", 0, ais_detected_state);
	endtask

	task automatic stop_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_loss();
		t_lock();
		t_rai();
		t_excess();
		t_search();
		t_irq();
		t_zero();
		t_crc_mf();
		t_ais_two();
		stop_test();
	end

	// About 8300 cycles expected; 21250, over two and a half times that, is a hang
	initial begin
		#170000;
		failures++;
		stop_test();
	end
endmodule // tb
